// ---- rjle_pkg.sv ----
package rjle_pkg;

	localparam int XLEN       = 64;
	localparam int LINK_DELTA = 8;
	localparam logic [4:0] LINK_DEFAULT_REG = 5'h1F;

	// Primary opcodes (bits 31..26).
	localparam logic [5:0] OP_SPECIAL    = 6'h00;
	localparam logic [5:0] OP_LDL        = 6'h1A;
	localparam logic [5:0] OP_LDR_UNUSED = 6'h1B;
	localparam logic [5:0] OP_LB         = 6'h20;
	localparam logic [5:0] OP_LBU        = 6'h24;
	localparam logic [5:0] OP_LD         = 6'h37;
	localparam logic [3:0] OP_LDC_HI     = 4'hD;
	// Function codes for the register jumps.
	localparam logic [5:0] FN_JR         = 6'h08;
	localparam logic [5:0] FN_LINKING_REGISTER_JUMP       = 6'h09;

	localparam logic [1:0] COP_SYSTEM    = 2'h0;
	localparam int         COP_COUNT     = 4;

	typedef enum logic [3:0]
	{
		RJLE_EXC_NONE   = 4'h0,
		RJLE_EXC_ADDR   = 4'h1,
		RJLE_EXC_TLBREF = 4'h2,
		RJLE_EXC_TLBINV = 4'h3,
		RJLE_EXC_BUS    = 4'h4,
		RJLE_EXC_RESV   = 4'h5,
		RJLE_EXC_COPUN  = 4'h6
	} rjle_exc_t;

	typedef enum logic [3:0]
	{
		RJLE_ST_IDLE = 4'b0001,
		RJLE_ST_WAIT = 4'b0010,
		RJLE_ST_DONE = 4'b0100,
		RJLE_ST_FAIL = 4'b1000
	} rjle_state_t;

	// Request toward the memory load path.
	typedef struct packed
	{
		logic            valid;
		logic [XLEN-1:0] addr;
		logic            dword;
	} rjle_memreq_t;

	// Answer from the memory load path.
	typedef struct packed
	{
		logic            valid;
		logic [XLEN-1:0] data;
		logic            tlbRefill;
		logic            tlbInvalid;
		logic            busError;
	} rjle_memrsp_t;

	// Register write-back toward the pipeline.
	typedef struct packed
	{
		logic            valid;
		logic [4:0]      reg_idx;
		logic [XLEN-1:0] data;
	} rjle_wb_t;

endpackage

// ---- rjle_lane_merge.sv ----
`timescale 1ns/100ps
// Byte extraction and left-part merge for the load data path.
module rjle_lane_merge #(
	parameter int XLEN = 64
) (
	input  wire logic [XLEN-1:0] memData,   // Aligned doubleword read
	input  wire logic [XLEN-1:0] oldReg,    // Current target register
	input  wire logic [2:0]      addrLow,   // Effective address bits 2..0
	input  wire logic            bigEndian, // Big-endian ordering active
	input  wire logic            signedLd,  // Sign-extend the byte
	output logic      [XLEN-1:0] byteOut,   // Extended byte result
	output logic      [XLEN-1:0] leftOut    // Left-merged result
);

	wire logic [2:0] laneIdx;
	wire logic [7:0] laneByte;
	wire logic [5:0] shiftAmt;
	wire logic [XLEN-1:0] keepMask;

	assign laneIdx = addrLow ^ {3{bigEndian}};
	assign laneByte = memData[{laneIdx, 3'b000} +: 8];
	assign byteOut = signedLd
		? {{(XLEN-8){laneByte[7]}}, laneByte}
		: {{(XLEN-8){1'b0}}, laneByte};

	// Lane n keeps 7-n old low bytes; memory bytes n..0 move to the top.
	assign shiftAmt = {3'(3'h7 - laneIdx), 3'b000};
	assign keepMask = ({{(XLEN-1){1'b0}}, 1'b1} << shiftAmt)
		- {{(XLEN-1){1'b0}}, 1'b1};
	assign leftOut = (memData << shiftAmt) | (oldReg & keepMask);

endmodule

// ---- rjle_exec.sv ----
`timescale 1ns/100ps
// Behaviour
// - linking jump writes own address plus eight
// - missing destination encodes register thirty one
// - delay slot runs before control moves
// - misaligned target faults at fetch, not jump
// - plain jump target from source, zero field
// - address is base plus sign-extended offset
// - signed byte load sign-extends the byte
// - unsigned byte load zero-extends the byte
// - byte loads report translation errors only, no address or bus errors
// - aligned doubleword load, misalignment faults
// - doubleword load reports five exception kinds
// - coprocessor load delivers aligned doubleword
// - four coprocessor units, zero to three; loads decode for units one and two only
// - unusable coprocessor raises unusable exception
// - coprocessor zero opcode is not this load
// - left load merges upper bytes only
// - merged bytes depend on address and ordering
module rjle_exec #(
	parameter int XLEN = rjle_pkg::XLEN
) (
	input  wire logic                  sys_clk,      // Core clock
	input  wire logic                  nrst,         // Async reset, low
	input  wire logic                  instValid,    // Instruction offered
	input  wire logic [31:0]           instWord,     // Instruction word
	input  wire logic [XLEN-1:0]       instPc,       // Instruction address
	input  wire logic [XLEN-1:0]       srcValue,     // Source/base value
	input  wire logic [XLEN-1:0]       tgtValue,     // Old target value
	input  wire logic                  bigEndianActive, // Byte order
	input  wire logic                  is64,         // 64-bit core mode
	input  wire logic [3:0]            copUsable,    // Usable bits
	input  wire rjle_pkg::rjle_memrsp_t memRsp,      // Load path answer
	output logic                       instReady,    // Can take instruction
	output rjle_pkg::rjle_memreq_t     memReq,       // Load path request
	output rjle_pkg::rjle_wb_t         writeBack,    // Register write
	output logic                       jumpValid,    // Jump after slot
	output logic      [XLEN-1:0]       jumpTarget,   // Jump destination
	output logic                       excValid,     // Exception pulse
	output rjle_pkg::rjle_exc_t        excCause,     // Exception cause
	output logic                       copLoadValid, // Coprocessor data
	output logic      [1:0]            copUnit,      // Coprocessor number
	output logic      [4:0]            copReg,       // Coprocessor register
	output logic      [XLEN-1:0]       copData       // Coprocessor data
);

	// Field decode.
	wire logic [5:0]  opcode;
	wire logic [5:0]  funct;
	wire logic [4:0]  srcField;
	wire logic [4:0]  tgtField;
	wire logic [4:0]  dstField;
	wire logic [14:0] zeroField;
	wire logic [15:0] offset;
	wire logic [1:0]  copSel;

	assign opcode    = instWord[31:26];
	assign srcField  = instWord[25:21];
	assign tgtField  = instWord[20:16];
	assign dstField  = instWord[15:11];
	assign zeroField = instWord[20:6];
	assign funct     = instWord[5:0];
	assign offset    = instWord[15:0];
	assign copSel    = instWord[27:26];

	wire logic isPlainJump;
	wire logic isLinkJump;
	wire logic isSignedByte;
	wire logic isUnsignedByte;
	wire logic isDword;
	wire logic isCopLoad;
	wire logic isLeftLoad;
	wire logic isLoad;
	wire logic isReserved;

	assign isPlainJump = opcode == rjle_pkg::OP_SPECIAL
		&& funct == rjle_pkg::FN_JR && zeroField == 15'h0000;
	assign isLinkJump = opcode == rjle_pkg::OP_SPECIAL
		&& funct == rjle_pkg::FN_LINKING_REGISTER_JUMP;
	assign isSignedByte   = opcode == rjle_pkg::OP_LB;
	assign isUnsignedByte = opcode == rjle_pkg::OP_LBU;
	assign isDword        = opcode == rjle_pkg::OP_LD;
	// The coprocessor zero slot belongs to another instruction, and the
	// coprocessor three slot is the doubleword load's own opcode.
	assign isCopLoad = opcode[5:2] == rjle_pkg::OP_LDC_HI
		&& copSel != rjle_pkg::COP_SYSTEM
		&& opcode != rjle_pkg::OP_LD;
	assign isLeftLoad = opcode == rjle_pkg::OP_LDL;
	assign isLoad = isSignedByte | isUnsignedByte | isDword
		| isCopLoad | isLeftLoad;
	// The doubleword and left loads are reserved outside 64-bit mode; coprocessor loads are not.
	assign isReserved = (isDword | isLeftLoad) & ~is64;

	// Effective address.
	wire logic [XLEN-1:0] effective_address;
	wire logic            misaligned;
	wire logic            copUnusable;

	assign effective_address = srcValue
		+ {{(XLEN-16){offset[15]}}, offset};
	assign misaligned = (isDword | isCopLoad)
		&& effective_address[2:0] != 3'h0;
	assign copUnusable = isCopLoad && !copUsable[copSel];

	// Held context of a load in flight.
	rjle_pkg::rjle_state_t state;
	rjle_pkg::rjle_state_t next_state;
	logic [4:0]      heldTgt;
	logic [XLEN-1:0] heldOld;
	logic [2:0]      heldLow;
	logic            heldSigned;
	logic            heldByte;
	logic            heldLeft;
	logic            heldCop;
	logic [1:0]      heldCopSel;
	logic            heldBig;
	logic            held64;

	wire logic takeInst;
	wire logic takeLoad;
	wire logic loadFault;
	wire logic rspFault;

	assign instReady = state == rjle_pkg::RJLE_ST_IDLE;
	assign takeInst  = instValid & instReady;
	assign loadFault = isReserved | misaligned | copUnusable;
	assign takeLoad  = takeInst & isLoad & ~loadFault;
	// Byte loads carry no bus error report.
	assign rspFault = memRsp.tlbRefill | memRsp.tlbInvalid
		| (memRsp.busError & ~heldByte);

	always_comb
	begin
		next_state = state;
		case (state)
			rjle_pkg::RJLE_ST_IDLE:
				if (takeLoad)
					next_state = rjle_pkg::RJLE_ST_WAIT;
			rjle_pkg::RJLE_ST_WAIT:
				if (memRsp.valid)
					next_state = rspFault ? rjle_pkg::RJLE_ST_FAIL
						: rjle_pkg::RJLE_ST_DONE;
			rjle_pkg::RJLE_ST_DONE:
				next_state = rjle_pkg::RJLE_ST_IDLE;
			rjle_pkg::RJLE_ST_FAIL:
				next_state = rjle_pkg::RJLE_ST_IDLE;
			default:
				next_state = rjle_pkg::RJLE_ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			state <= rjle_pkg::RJLE_ST_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			{heldTgt, heldOld, heldLow, heldSigned, heldByte, heldLeft,
				heldCop, heldCopSel, heldBig, held64} <= '0;
		else if (takeLoad)
		begin
			heldTgt    <= tgtField;
			heldOld    <= tgtValue;
			heldLow    <= effective_address[2:0];
			heldSigned <= isSignedByte;
			heldByte   <= isSignedByte | isUnsignedByte;
			heldLeft   <= isLeftLoad;
			heldCop    <= isCopLoad;
			heldCopSel <= copSel;
			heldBig    <= bigEndianActive;
			held64     <= is64;
		end
	end

	// Memory request is a one-cycle pulse with the full effective address.
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			memReq <= '0;
		else
		begin
			memReq.valid <= takeLoad;
			memReq.addr  <= effective_address;
			memReq.dword <= isDword | isCopLoad | isLeftLoad;
		end
	end

	// Data path.
	wire logic [XLEN-1:0] byteResult;
	wire logic [XLEN-1:0] leftResult;
	wire logic [2:0]      laneLow;
	logic      [XLEN-1:0] rspData;

	// On 32-bit cores the byte comes from the low word; bit two is preset so
	// that the endian flip in the merge unit clears it again.
	assign laneLow = held64 ? heldLow : {heldBig, heldLow[1:0]};

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			rspData <= '0;
		else if (state == rjle_pkg::RJLE_ST_WAIT && memRsp.valid)
			rspData <= memRsp.data;
	end

	rjle_lane_merge #(
		.XLEN(XLEN)
	) u_merge (
		.memData  (rspData),
		.oldReg   (heldOld),
		.addrLow  (laneLow),
		.bigEndian(heldBig & held64 | heldBig & heldByte),
		.signedLd (heldSigned),
		.byteOut  (byteResult),
		.leftOut  (leftResult)
	);

	wire logic doneLoad;
	wire logic linkTake;
	wire logic [4:0] linkReg;

	assign doneLoad = state == rjle_pkg::RJLE_ST_DONE;
	assign linkTake = takeInst & isLinkJump;
	// The assembler fills in register 31 when none is written.
	assign linkReg = dstField;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			writeBack <= '0;
		else if (linkTake)
		begin
			writeBack.valid   <= 1'b1;
			writeBack.reg_idx <= linkReg;
			writeBack.data    <= instPc
				+ XLEN'(rjle_pkg::LINK_DELTA);
		end
		else if (doneLoad && !heldCop)
		begin
			writeBack.valid   <= 1'b1;
			writeBack.reg_idx <= heldTgt;
			writeBack.data    <= heldByte ? byteResult
				: heldLeft ? leftResult : rspData;
		end
		else
			writeBack.valid <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			{copLoadValid, copUnit, copReg, copData} <= '0;
		else
		begin
			copLoadValid <= doneLoad & heldCop;
			copUnit      <= heldCopSel;
			copReg       <= heldTgt;
			copData      <= rspData;
		end
	end

	// The target is sampled from the source before the link lands, and the
	// pipeline redirects only after the delay slot. No alignment check here.
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			{jumpValid, jumpTarget} <= '0;
		else
		begin
			jumpValid <= takeInst & (isPlainJump | isLinkJump);
			if (takeInst & (isPlainJump | isLinkJump))
				jumpTarget <= srcValue;
		end
	end

	rjle_pkg::rjle_exc_t next_cause;

	always_comb
	begin
		next_cause = rjle_pkg::RJLE_EXC_NONE;
		if (takeInst && isLoad)
		begin
			if (isReserved)
				next_cause = rjle_pkg::RJLE_EXC_RESV;
			else if (copUnusable)
				next_cause = rjle_pkg::RJLE_EXC_COPUN;
			else if (misaligned)
				next_cause = rjle_pkg::RJLE_EXC_ADDR;
		end
		else if (state == rjle_pkg::RJLE_ST_WAIT && memRsp.valid)
		begin
			if (memRsp.tlbRefill)
				next_cause = rjle_pkg::RJLE_EXC_TLBREF;
			else if (memRsp.tlbInvalid)
				next_cause = rjle_pkg::RJLE_EXC_TLBINV;
			else if (memRsp.busError && !heldByte)
				next_cause = rjle_pkg::RJLE_EXC_BUS;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			excValid <= 1'b0;
			excCause <= rjle_pkg::RJLE_EXC_NONE;
		end
		else
		begin
			excValid <= next_cause != rjle_pkg::RJLE_EXC_NONE;
			excCause <= next_cause;
		end
	end

	a_link_value: assert property (@(posedge sys_clk) disable iff (!nrst)
		linkTake |=> writeBack.valid
			&& writeBack.data == $past(instPc) + 64'h8)
		else $error("link value wrong");
	a_jump_target: assert property (@(posedge sys_clk) disable iff (!nrst)
		takeInst && (isPlainJump || isLinkJump)
			|=> jumpValid && jumpTarget == $past(srcValue))
		else $error("jump target wrong");
	a_jump_noexc: assert property (@(posedge sys_clk) disable iff (!nrst)
		takeInst && (isPlainJump || isLinkJump) |=> !excValid)
		else $error("jump raised exception");
	a_dword_align: assert property (@(posedge sys_clk) disable iff (!nrst)
		takeInst && isDword && is64 && effective_address[2:0] != 3'h0
			|=> excValid && excCause == rjle_pkg::RJLE_EXC_ADDR
			&& !memReq.valid)
		else $error("misaligned load not faulted");
	a_cop_unusable: assert property (@(posedge sys_clk) disable iff (!nrst)
		takeInst && copUnusable
			|=> excCause == rjle_pkg::RJLE_EXC_COPUN)
		else $error("unusable coprocessor not faulted");
	a_byte_nobus: assert property (@(posedge sys_clk) disable iff (!nrst)
		state == rjle_pkg::RJLE_ST_WAIT && memRsp.valid && heldByte
			&& !memRsp.tlbRefill && !memRsp.tlbInvalid
			|=> !excValid ##1 writeBack.valid)
		else $error("byte load reported bus error");
	a_load_wb: assert property (@(posedge sys_clk) disable iff (!nrst)
		doneLoad && !heldCop |=> writeBack.valid
			&& writeBack.reg_idx == $past(heldTgt))
		else $error("load write-back missing");
	a_cop_deliver: assert property (@(posedge sys_clk) disable iff (!nrst)
		doneLoad && heldCop |=> copLoadValid && !writeBack.valid
			&& copUnit != 2'h0)
		else $error("coprocessor delivery wrong");
	a_load_ea: assert property (@(posedge sys_clk) disable iff (!nrst)
		takeLoad |=> memReq.valid && memReq.addr
			== $past(srcValue) + {{48{$past(offset[15])}},
			$past(offset)})
		else $error("effective address wrong");

	c_link_jump: cover property (@(posedge sys_clk) linkTake);
	c_byte_load: cover property (@(posedge sys_clk)
		doneLoad && heldByte);
	c_left_load: cover property (@(posedge sys_clk)
		doneLoad && heldLeft);
	c_cop_load: cover property (@(posedge sys_clk) copLoadValid);

endmodule

// ---- rjle_mem_model.sv ----
`timescale 1ns/100ps
// Load path stand-in: answers each request after a chosen delay.
module rjle_mem_model (
	input  wire logic                   sys_clk,  // Core clock
	input  wire logic                   nrst,     // Async reset, low
	input  wire rjle_pkg::rjle_memreq_t memReq,   // Request from block
	input  wire logic [63:0]            rspData,  // Data to return
	input  wire logic [1:0]             rspFault, // 1 refill 2 invalid 3 bus
	input  wire logic [3:0]             rspDelay, // Cycles before answer
	output rjle_pkg::rjle_memrsp_t      memRsp    // Answer to block
);
	logic [3:0] count;
	logic       busy;
	logic       fire;

	assign fire = busy && (count == 4'h0);

	// Outside an answer the data lines toggle, so stale data never passes.
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			busy <= 1'b0;
			count <= 4'h0;
			memRsp <= '0;
		end
		else
		begin
			memRsp.valid <= fire;
			memRsp.data <= fire ? rspData : ~memRsp.data;
			memRsp.tlbRefill <= fire && (rspFault == 2'h1);
			memRsp.tlbInvalid <= fire && (rspFault == 2'h2);
			memRsp.busError <= fire && (rspFault == 2'h3);
			if (memReq.valid)
			begin
				busy <= 1'b1;
				count <= rspDelay;
			end
			else if (fire)
				busy <= 1'b0;
			else if (busy)
				count <= count - 4'h1;
		end
	end
endmodule

// ---- rjle_exec_bench.sv ----
`timescale 1ns/100ps
module rjle_exec_bench;
	typedef struct packed
	{
		logic [1:0]  kind;
		logic [6:0]  idx;
		logic [63:0] data;
	} rjle_note_t;

	logic                   sys_clk;
	logic                   nrst;
	logic                   instValid;
	logic [31:0]            instWord;
	logic [63:0]            instPc;
	logic [63:0]            srcValue;
	logic [63:0]            tgtValue;
	logic                   bigEndianActive;
	logic                   is64;
	logic [3:0]             copUsable;
	logic                   instReady;
	logic                   jumpValid;
	logic [63:0]            jumpTarget;
	logic                   excValid;
	rjle_pkg::rjle_exc_t    excCause;
	logic                   copLoadValid;
	logic [1:0]             copUnit;
	logic [4:0]             copReg;
	logic [63:0]            copData;
	rjle_pkg::rjle_memreq_t memReq;
	rjle_pkg::rjle_memrsp_t memRsp;
	rjle_pkg::rjle_wb_t     writeBack;
	logic [63:0]            rspData;
	logic [1:0]             rspFault;
	logic [3:0]             rspDelay;
	logic [63:0]            expAddr;
	logic                   expDword;
	logic [63:0]            ea;
	logic [63:0]            s;
	logic [63:0]            bs;
	logic [1:0]             f;
	logic [1:0]             u;
	logic [2:0]             ln;
	logic [7:0]             b;
	logic                   taken;
	int                     sh;
	int unsigned            seedTmp;
	rjle_note_t             noteQ[$];
	int                     n_mismatch;
	int                     n_tests;
	int                     cycles;

	rjle_exec u_dut (
		.sys_clk         (sys_clk),
		.nrst            (nrst),
		.instValid       (instValid),
		.instWord        (instWord),
		.instPc          (instPc),
		.srcValue        (srcValue),
		.tgtValue        (tgtValue),
		.bigEndianActive (bigEndianActive),
		.is64            (is64),
		.copUsable       (copUsable),
		.memRsp          (memRsp),
		.instReady       (instReady),
		.memReq          (memReq),
		.writeBack       (writeBack),
		.jumpValid       (jumpValid),
		.jumpTarget      (jumpTarget),
		.excValid        (excValid),
		.excCause        (excCause),
		.copLoadValid    (copLoadValid),
		.copUnit         (copUnit),
		.copReg          (copReg),
		.copData         (copData)
	);

	rjle_mem_model u_mem (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.memReq   (memReq),
		.rspData  (rspData),
		.rspFault (rspFault),
		.rspDelay (rspDelay),
		.memRsp   (memRsp)
	);

	always #5 sys_clk = ~sys_clk;

	always @(posedge sys_clk)
		taken <= instValid && instReady;

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_mismatch++;
			$display("unexpected cycles: expected below 3000 seen 3000");
			tally_and_finish();
		end
	end

	task automatic chk(input logic [1:0] k, input logic [6:0] i,
		input logic [63:0] d);
		rjle_note_t e;
		n_tests++;
		e = (noteQ.size() > 0) ? noteQ.pop_front() : '1;
		if (e.kind !== k || e.idx !== i || e.data !== d)
		begin
			n_mismatch++;
			$display("unexpected result %0d: expected %h %h seen %h %h",
				k, e.idx, e.data, i, d);
		end
	endtask

	// Results are checked mid-cycle, where every registered pulse is settled.
	always @(negedge sys_clk)
	begin
		if (memReq.valid === 1'b1)
		begin
			n_tests++;
			if (memReq.addr !== expAddr || memReq.dword !== expDword)
			begin
				n_mismatch++;
				$display("unexpected request: expected %h %b seen %h %b",
					expAddr, expDword, memReq.addr, memReq.dword);
			end
		end
		if (writeBack.valid === 1'b1)
			chk(2'h0, {2'h0, writeBack.reg_idx}, writeBack.data);
		if (jumpValid === 1'b1)
			chk(2'h1, 7'h00, jumpTarget);
		if (excValid === 1'b1)
			chk(2'h2, 7'h00, {60'h0, excCause});
		if (copLoadValid === 1'b1)
			chk(2'h3, {copUnit, copReg}, copData);
	end

	function automatic void note(input logic [1:0] k, input logic [6:0] i,
		input logic [63:0] d);
		noteQ.push_back({k, i, d});
	endfunction

	task automatic go(input logic [31:0] w, input logic [63:0] v);
		instWord = w;
		srcValue = v;
		instValid = 1'b1;
		do
		begin
			@(posedge sys_clk);
			#1;
		end
		while (taken !== 1'b1);
		instPc = instPc + 64'h4;
	endtask

	task automatic ld(input logic [5:0] op, input logic [15:0] off,
		input logic [63:0] base, input logic [1:0] flt);
		ea = base + {{48{off[15]}}, off};
		expAddr = ea;
		expDword = op != rjle_pkg::OP_LB && op != rjle_pkg::OP_LBU;
		rspData = {$urandom, $urandom};
		rspFault = flt;
		rspDelay = 4'($urandom_range(3));
		tgtValue = {$urandom, $urandom};
		go({op, 5'h03, 5'h07, off}, base);
		instValid = 1'b0;
	endtask

	// Mode inputs change only while no load is outstanding.
	task automatic settle();
		do
		begin
			@(posedge sys_clk);
			#1;
		end
		while (instReady !== 1'b1);
	endtask

	initial
	begin
		seedTmp = $urandom(78);
		sys_clk = 1'b0;
		nrst = 1'b0;
		instValid = 1'b0;
		instWord = 32'h0;
		instPc = {$urandom, $urandom} & ~64'h3;
		srcValue = 64'h0;
		tgtValue = 64'h0;
		bigEndianActive = 1'b0;
		is64 = 1'b1;
		copUsable = 4'h6;
		rspData = 64'h0;
		rspFault = 2'h0;
		rspDelay = 4'h0;
		expAddr = 64'h0;
		repeat (8) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		s = {$urandom, $urandom} & ~64'h3;
		go({6'h00, 5'h04, 5'h00, 5'h05, 5'h00, rjle_pkg::FN_LINKING_REGISTER_JUMP}, s);
		note(2'h0, 7'h05, instPc + 64'h4);
		note(2'h1, 7'h00, s);
		go({6'h00, 5'h04, 5'h00, 5'h1F, 5'h00, rjle_pkg::FN_LINKING_REGISTER_JUMP}, s | 64'h1);
		note(2'h0, 7'h1F, instPc + 64'h4);
		note(2'h1, 7'h00, s | 64'h1);
		go({6'h00, 5'h06, 15'h0100, rjle_pkg::FN_JR}, ~s);
		go({6'h00, 5'h06, 15'h0000, rjle_pkg::FN_JR}, s);
		note(2'h1, 7'h00, s);
		instValid = 1'b0;
		settle();
		$display("test jumps done");
		for (int i = 0; i < 32; i++)
		begin
			bigEndianActive = 1'($urandom);
			is64 = i[1];
			f = (i[2:0] == 3'h5) ? i[4:3] : 2'h0;
			ld(i[0] ? rjle_pkg::OP_LBU : rjle_pkg::OP_LB, 16'($urandom),
				{$urandom, $urandom}, f);
			ln = is64 ? ea[2:0] ^ {3{bigEndianActive}}
				: {1'b0, ea[1:0] ^ {2{bigEndianActive}}};
			b = rspData[8 * ln +: 8];
			if (f == 2'h1 || f == 2'h2)
				note(2'h2, 7'h00, {62'h0, f} + 64'h1);
			else
				note(2'h0, 7'h07, {{56{b[7] & ~i[0]}}, b});
			settle();
		end
		$display("test byte loads done");
		for (int i = 0; i < 8; i++)
		begin
			is64 = (i != 5);
			bs = ({$urandom, $urandom} & ~64'h7) | ((i == 1) ? 64'h4 : 64'h0);
			f = (i >= 2 && i <= 4) ? 2'(i - 1) : 2'h0;
			ld(rjle_pkg::OP_LD, {13'($urandom), 3'h0}, bs, f);
			if (i == 1)
				note(2'h2, 7'h00, {60'h0, rjle_pkg::RJLE_EXC_ADDR});
			else if (i == 5)
				note(2'h2, 7'h00, {60'h0, rjle_pkg::RJLE_EXC_RESV});
			else if (f != 2'h0)
				note(2'h2, 7'h00, {62'h0, f} + 64'h1);
			else
				note(2'h0, 7'h07, rspData);
			settle();
		end
		is64 = 1'b1;
		$display("test doubleword loads done");
		for (int z = 0; z < 5; z++)
		begin
			u = (z == 4) ? 2'h1 : (z == 3) ? 2'h2 : 2'(z);
			copUsable = (z == 3) ? 4'h2 : 4'h6;
			bs = ({$urandom, $urandom} & ~64'h7) | ((z == 4) ? 64'h2 : 64'h0);
			ld({rjle_pkg::OP_LDC_HI, u}, 16'h0010, bs, 2'h0);
			if (z == 3)
				note(2'h2, 7'h00, {60'h0, rjle_pkg::RJLE_EXC_COPUN});
			else if (z == 4)
				note(2'h2, 7'h00, {60'h0, rjle_pkg::RJLE_EXC_ADDR});
			else if (z != 0)
				note(2'h3, {u, 5'h07}, rspData);
			settle();
		end
		$display("test coprocessor loads done");
		for (int k = 0; k < 16; k++)
		begin
			bigEndianActive = k[3];
			bs = ({$urandom, $urandom} & ~64'h7) | 64'(k[2:0]);
			ld(rjle_pkg::OP_LDL, {13'($urandom), 3'h0}, bs, 2'h0);
			sh = 8 * (7 - int'(ea[2:0] ^ {3{k[3]}}));
			note(2'h0, 7'h07, (rspData << sh)
				| (tgtValue & ((64'h1 << sh) - 64'h1)));
			settle();
		end
		$display("test left loads done");
		repeat (4) @(posedge sys_clk);
		if (noteQ.size() != 0)
		begin
			n_mismatch++;
			$display("unexpected pending: expected 0 seen %0d", noteQ.size());
		end
		tally_and_finish();
	end
endmodule
